// ---- design/ecp_parallel_handshake.sv ----
// Host-side handshake engine of a multi-mode parallel port.
// Assumes Busy, nAck and nFault are asynchronous and pass two flops on clk_sys first, and that
// the pad ring resolves the wire level from each output and its enable.
// Functional notes
// R1 - FIFO mode paces on Busy, ignores nAck
// R2 - FIFO mode only forward, fed from buffer
// R3 - Forward idle: nStrobe high, Busy low
// R4 - Forward interlock: strobe low, busy, release
// R5 - Peripheral may raise reverse request anytime; reported only in ECP mode with the forward direction
// R6 - Reverse idle: nAck high, nAutoFd low
// R7 - Reverse interlock: autofd high, ack, lower
// R8 - Push-pull in ECP, open-collector otherwise
// R9 - Busy change valid after steady window
// R10 - nAck change valid after steady window
// R11 - Stall reverse on full buffer or terminal count
// R12 - Next strobe only with waiting byte
// R13 - Direction bit set before EPP read
// R14 - Synchronise Busy, nAck, nFault first
module ecp_parallel_handshake
	import pp_hs_pkg::*;
(
	// Clock and reset
	input  wire logic                   clk_sys,
	input  wire logic                   reset,
	// Mode control
	input  wire pp_hs_pkg::mode_t       mode,
	input  wire logic                   port_direction_bit,
	input  wire logic                   terminal_count,
	// Forward data from DMA
	input  wire logic [DATA_W-1:0]      tx_data,
	input  wire logic                   tx_valid,
	output logic                        tx_ready,
	// Reverse data to DMA
	output logic [DATA_W-1:0]           rx_data,
	output logic                        rx_valid,
	input  wire logic                   rx_ready,
	// Peripheral inputs
	input  wire logic                   busy_in,
	input  wire logic                   nack_in,
	input  wire logic                   nfault_in,
	// Data pins
	input  wire logic [DATA_W-1:0]      pdata_in,
	output logic [DATA_W-1:0]           pdata_out,
	output logic [DATA_W-1:0]           pdata_oe,
	// Handshake pins
	output logic                        nstrobe_out,
	output logic                        nstrobe_oe,
	output logic                        nautofd_out,
	output logic                        nautofd_oe,
	output logic                        nwrite_out,
	// Status
	output logic                        reverse_request
);
	import pp_hs_pkg::*;

	logic [IN_W-1:0]   sync1;
	logic [IN_W-1:0]   sync2;
	logic [1:0]        filt;
	logic [1:0]        next_filt;
	logic [CNT_W-1:0]  fcnt [2];
	logic [CNT_W-1:0]  next_fcnt [2];
	state_t            state;
	state_t            next_state;
	logic [CNT_W-1:0]  dly;
	logic [CNT_W-1:0]  next_dly;
	mode_t             cur_mode;
	mode_t             next_mode;
	logic              cur_dir;
	logic              next_dir;
	logic              nstrobe_lvl;
	logic              next_nstrobe;
	logic              nautofd_lvl;
	logic              next_nautofd;
	logic [DATA_W-1:0] next_pdata;
	logic [DATA_W-1:0] rx_word;
	logic [DATA_W-1:0] next_rx_word;
	logic              rx_push;
	logic              next_rx_push;
	logic              rev;
	logic              drive_oc;
	logic              busy_f;
	logic              nack_f;
	logic [DATA_W-1:0] txb_data;
	logic              txb_valid;
	logic              txb_pop;
	logic              rxb_ready;

	// Forward path buffer: a stalled peripheral backs up into tx_ready
	pp_buffer2 tx_buf (
		.clk_sys   (clk_sys),
		.reset     (reset),
		.in_data   (tx_data),
		.in_valid  (tx_valid),
		.in_ready  (tx_ready),
		.out_data  (txb_data),
		.out_valid (txb_valid),
		.out_ready (txb_pop)
	);

	// Reverse path buffer: full means the peripheral is held off
	pp_buffer2 rx_buf (
		.clk_sys   (clk_sys),
		.reset     (reset),
		.in_data   (rx_word),
		.in_valid  (rx_push),
		.in_ready  (rxb_ready),
		.out_data  (rx_data),
		.out_valid (rx_valid),
		.out_ready (rx_ready)
	);

	// Mode and drive type latched only at idle, so no pin flips mid-cycle
	assign rev      = (cur_mode == MODE_ECP) && cur_dir;         // [R2]
	assign drive_oc = (cur_mode == MODE_FIFO);                   // [R8]
	assign busy_f   = filt[IN_BUSY];
	assign nack_f   = filt[IN_NACK];
	assign txb_pop  = (state == ST_IDLE) && !rev && txb_valid && !busy_f; // [R12]

	// Open-collector drives only lows; push-pull drives whichever side owns
	always_comb begin
		nstrobe_out = nstrobe_lvl;
		nautofd_out = nautofd_lvl;
		nstrobe_oe  = drive_oc ? !nstrobe_lvl : 1'b1;            // [R8]
		nautofd_oe  = drive_oc ? !nautofd_lvl : 1'b1;            // [R8]
		pdata_oe    = rev ? '0 : (drive_oc ? ~pdata_out : '1);   // [R8]
	end

	// Input settling: a level counts once steady for the full window
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			next_filt[i] = filt[i];
			next_fcnt[i] = CNT_ZERO;
			if (sync2[i] != filt[i]) begin
				if (fcnt[i] == FILTER_LAST) begin
					next_filt[i] = sync2[i];                     // [R9] [R10]
				end else begin
					next_fcnt[i] = fcnt[i] + 4'h1;
				end
			end
		end
	end

	// Handshake sequencer for both directions
	always_comb begin
		next_state   = state;
		next_dly     = CNT_ZERO;
		next_mode    = cur_mode;
		next_dir     = cur_dir;
		next_nstrobe = nstrobe_lvl;
		next_nautofd = nautofd_lvl;
		next_pdata   = pdata_out;
		next_rx_word = rx_word;
		next_rx_push = 1'b0;
		unique case (state)
			ST_IDLE: begin
				next_mode    = mode;
				next_dir     = port_direction_bit;
				next_nstrobe = 1'b1;                             // [R3]
				next_nautofd = !rev;                             // [R6]
				if (txb_pop) begin
					next_pdata = txb_data;                       // [R4]
					next_state = ST_F_SETUP;
				end else if (rev && !nack_f && rxb_ready && !terminal_count) begin
					next_state = ST_R_DELAY;                     // [R11]
				end
			end
			ST_F_SETUP: begin
				next_dly = dly + 4'h1;
				if (dly == DLY_LAST) begin
					next_nstrobe = 1'b0;                         // [R4]
					next_state   = ST_F_STROBE;
				end
			end
			ST_F_STROBE: begin
				if (busy_f) begin                                // [R1]
					next_state = ST_F_HOLD;
				end
			end
			ST_F_HOLD: begin
				next_dly = dly + 4'h1;
				if (dly == DLY_LAST) begin
					next_nstrobe = 1'b1;                         // [R4]
					next_state   = ST_F_WAIT;
				end
			end
			ST_F_WAIT: begin
				if (!busy_f) begin                               // [R1]
					next_state = ST_IDLE;
				end
			end
			ST_R_DELAY: begin
				next_dly = dly + 4'h1;
				if (dly == DLY_LAST) begin
					next_nautofd = 1'b1;                         // [R7]
					next_rx_word = pdata_in;
					next_rx_push = 1'b1;
					next_state   = ST_R_ACK;
				end
			end
			ST_R_ACK: begin
				if (nack_f) begin
					next_state = ST_R_HOLD;
				end
			end
			ST_R_HOLD: begin
				next_dly = dly + 4'h1;
				if (dly == DLY_LAST) begin
					next_nautofd = 1'b0;                         // [R7]
					next_state   = ST_IDLE;
				end
			end
		endcase
	end

	// Registers; the first synchroniser stage feeds only the second
	always_ff @(posedge clk_sys) begin
		sync1 <= {nfault_in, nack_in, busy_in};                  // [R14]
		sync2 <= sync1;                                          // [R14]
		if (reset) begin
			filt        <= 2'h3;
			fcnt[0]     <= CNT_ZERO;
			fcnt[1]     <= CNT_ZERO;
			state       <= ST_IDLE;
			dly         <= CNT_ZERO;
			cur_mode    <= MODE_FIFO;
			cur_dir     <= 1'b0;
			nstrobe_lvl <= 1'b1;
			nautofd_lvl <= 1'b1;
			pdata_out   <= '0;
			rx_word     <= '0;
			rx_push     <= 1'b0;
		end else begin
			filt        <= next_filt;
			fcnt[0]     <= next_fcnt[0];
			fcnt[1]     <= next_fcnt[1];
			state       <= next_state;
			dly         <= next_dly;
			cur_mode    <= next_mode;
			cur_dir     <= next_dir;
			nstrobe_lvl <= next_nstrobe;
			nautofd_lvl <= next_nautofd;
			pdata_out   <= next_pdata;
			rx_word     <= next_rx_word;
			rx_push     <= next_rx_push;
		end
	end

	// Direction level on nWrite; software must set it before a read
	assign nwrite_out      = cur_dir;                            // [R13]
	assign reverse_request = (cur_mode == MODE_ECP) && !cur_dir && !sync2[IN_NFAULT]; // [R5]

	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);

	a_fwd_idle_strobe: assert property (state == ST_IDLE |-> nstrobe_lvl) // [R3]
		else $error("nStrobe low in idle");
	a_strobe_needs_free: assert property ($fell(nstrobe_lvl) |-> // [R4]
		!busy_f && $past(dly) == DLY_LAST)
		else $error("strobe without settled free peripheral");
	a_strobe_release: assert property ($rose(nstrobe_lvl) |-> $past(busy_f)) // [R4]
		else $error("strobe raised before busy ack");
	a_busy_settle: assert property ($changed(filt[IN_BUSY]) |-> $past(fcnt[0]) == FILTER_LAST) // [R9]
		else $error("busy accepted before window");
	a_nack_settle: assert property ($changed(filt[IN_NACK]) |-> $past(fcnt[1]) == FILTER_LAST) // [R10]
		else $error("nack accepted before window");
	a_rev_stall: assert property (state == ST_IDLE && rev && (!rxb_ready || terminal_count) // [R11]
		|=> !nautofd_lvl)
		else $error("reverse not stalled");
	a_rev_idle_low: assert property (state == ST_IDLE && rev |=> // [R6]
		!nautofd_lvl || state != ST_IDLE)
		else $error("nAutoFd high in reverse idle");
	a_rev_capture: assert property ($rose(nautofd_lvl) && rev |-> rx_push ##1 !rx_push) // [R7]
		else $error("byte not captured on ack");
	a_fifo_forward: assert property (cur_mode == MODE_FIFO |-> !rev && nautofd_lvl) // [R2]
		else $error("FIFO mode left forward");
	a_open_drain: assert property (drive_oc && nstrobe_oe |-> !nstrobe_out) // [R8]
		else $error("open-collector drove high");
	a_sync_fault: assert property (reverse_request |-> $past(nfault_in, 2) == 1'b0) // [R14]
		else $error("reverse request not synchronised");

	c_fwd_byte: cover property ($rose(nstrobe_lvl) ##[1:40] state == ST_IDLE);
	c_rev_byte: cover property (rx_push ##[1:40] !nautofd_lvl);
	c_rev_stall: cover property (rev && !rxb_ready && !nack_f);
	c_tx_backpressure: cover property (!tx_ready && tx_valid);

endmodule

// ---- design/pp_hs_pkg.sv ----
// Constants and types shared by the parallel port handshake block.
// Assumes one system clock of 125 MHz; all times become cycle counts here.
package pp_hs_pkg;

	localparam int DATA_W         = 8;
	localparam int CLK_NS         = 8;
	// Least time an input must stay steady before a change counts
	localparam int FILTER_NS      = 75;
	localparam int FILTER_CYC     = (FILTER_NS + CLK_NS - 1) / CLK_NS;
	// Least gap from a settled handshake edge to the next host edge
	localparam int EDGE_DLY_NS    = 80;
	localparam int EDGE_DLY_CYC   = (EDGE_DLY_NS + CLK_NS - 1) / CLK_NS;
	// Peak forward rate of the FIFO-driven standard mode, for reference
	localparam int FIFO_PEAK_KBPS = 500;
	localparam int CNT_W          = 4;
	localparam logic [CNT_W-1:0] FILTER_LAST = 4'(FILTER_CYC - 1);
	localparam logic [CNT_W-1:0] DLY_LAST    = 4'(EDGE_DLY_CYC - 1);
	localparam logic [CNT_W-1:0] CNT_ZERO    = 4'h0;

	// Input bit positions inside the synchroniser vector
	localparam int IN_BUSY   = 0;
	localparam int IN_NACK   = 1;
	localparam int IN_NFAULT = 2;
	localparam int IN_W      = 3;

	typedef enum logic {
		MODE_FIFO,
		MODE_ECP
	} mode_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_F_SETUP,
		ST_F_STROBE,
		ST_F_HOLD,
		ST_F_WAIT,
		ST_R_DELAY,
		ST_R_ACK,
		ST_R_HOLD
	} state_t;

endpackage

// ---- design/pp_buffer2.sv ----
// Two-entry buffer with valid and ready on both sides.
// Assumes both sides run on clk_sys; a stall on the drain side fills it.
module pp_buffer2
	import pp_hs_pkg::*;
(
	// Clock and reset
	input  wire logic              clk_sys,
	input  wire logic              reset,
	// Filling side
	input  wire logic [DATA_W-1:0] in_data,
	input  wire logic              in_valid,
	output logic                   in_ready,
	// Draining side
	output logic [DATA_W-1:0]      out_data,
	output logic                   out_valid,
	input  wire logic              out_ready
);
	import pp_hs_pkg::*;

	logic [DATA_W-1:0] mem [2];
	logic              wr_ptr;
	logic              rd_ptr;
	logic [1:0]        count;
	logic              next_wr_ptr;
	logic              next_rd_ptr;
	logic [1:0]        next_count;
	logic              push;
	logic              pop;

	// Honest flags: ready only with a free slot, valid only when holding
	assign in_ready  = (count != 2'h2);
	assign out_valid = (count != 2'h0);
	assign out_data  = mem[rd_ptr];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// Pointer and occupancy update
	always_comb begin
		next_wr_ptr = wr_ptr ^ push;
		next_rd_ptr = rd_ptr ^ pop;
		next_count  = count + {1'b0, push} - {1'b0, pop};
	end

	// Storage has no reset; occupancy guards every read
	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
		if (reset) begin
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			count  <= 2'h0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count  <= next_count;
		end
	end

endmodule

// ---- tb/pp_periph_model.sv ----
// Peripheral model on the far end of the parallel cable.
// Assumes pulled-up cable lines; the bench resolves each wire level.
module pp_periph_model
	import pp_hs_pkg::*;
(
	// Clock
	input  wire logic              clk_sys,
	// Cable as seen by the peripheral
	input  wire logic              nstrobe,
	input  wire logic              nautofd,
	input  wire logic [DATA_W-1:0] pdata,
	output logic                   busy_in,
	output logic                   nack_in,
	output logic [DATA_W-1:0]      pdata_drv,
	// Bench control and observation
	input  wire logic [3:0]        slow,
	input  wire logic [3:0]        send_n,
	input  wire logic [DATA_W-1:0] send_base,
	output logic [DATA_W-1:0]      got_data,
	output logic [3:0]             got_cnt,
	output logic [3:0]             sent_cnt
);
	timeunit 1ns;
	timeprecision 1ps;
	// One transfer at a time, forward first; slow stretches each answer except the nAck fall
	initial begin
		busy_in = 1'b0;
		nack_in = 1'b1;
		pdata_drv = 8'hFF;
		got_data = 8'h00;
		got_cnt = 4'h0;
		sent_cnt = 4'h0;
		forever begin
			@(posedge clk_sys);
			if (nstrobe === 1'b0) begin
				repeat (slow) @(posedge clk_sys);
				busy_in <= 1'b1;
				while (nstrobe !== 1'b1) @(posedge clk_sys);
				repeat (slow) @(posedge clk_sys);
				got_data <= pdata;
				got_cnt <= got_cnt + 4'h1;
				busy_in <= 1'b0;
			end else if (sent_cnt != send_n && nautofd === 1'b0) begin
				// Never send before the host has lowered nAutoFd
				pdata_drv <= send_base + DATA_W'(sent_cnt);
				@(posedge clk_sys);
				nack_in <= 1'b0;
				while (nautofd !== 1'b1) @(posedge clk_sys);
				repeat (slow) @(posedge clk_sys);
				nack_in <= 1'b1;
				sent_cnt <= sent_cnt + 4'h1;
				@(posedge clk_sys);
				pdata_drv <= 8'hFF; // Released lines float up
			end
		end
	end
endmodule

// ---- tb/testbench.sv ----
// Self-checking bench for the parallel port handshake engine.
// Assumes the peripheral model on the cable and pulled-up cable lines.
module testbench
	import pp_hs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk_sys, reset, port_direction_bit, terminal_count, nfault_in;
	mode_t      mode;
	logic [7:0] tx_data, rx_data, pdata_out, pdata_oe, pdata_drv, pdata_w, got_data, send_base;
	logic       tx_valid, tx_ready, rx_valid, rx_ready, busy_in, nack_in, reverse_request;
	logic       nstrobe_out, nstrobe_oe, nautofd_out, nautofd_oe, nwrite_out;
	logic       nstrobe_w, nautofd_w, prev_stb, prev_afd;
	logic [3:0] slow, send_n, got_cnt, sent_cnt;
	int         fails = 0, n_checks = 0, hi_cnt = 0, lo_cnt = 0;
	// Cable levels; an undriven line sits at its pull-up
	assign nstrobe_w = nstrobe_oe ? nstrobe_out : 1'b1;
	assign nautofd_w = nautofd_oe ? nautofd_out : 1'b1;
	assign pdata_w = (pdata_oe & pdata_out) | (~pdata_oe & pdata_drv);
	ecp_parallel_handshake u_dut (.clk_sys, .reset, .mode, .port_direction_bit, .terminal_count,
		.tx_data, .tx_valid, .tx_ready, .rx_data, .rx_valid, .rx_ready, .busy_in, .nack_in,
		.nfault_in, .pdata_in(pdata_w), .pdata_out, .pdata_oe, .nstrobe_out, .nstrobe_oe,
		.nautofd_out, .nautofd_oe, .nwrite_out, .reverse_request);
	pp_periph_model u_periph (.clk_sys, .nstrobe(nstrobe_w), .nautofd(nautofd_w),
		.pdata(pdata_w), .busy_in, .nack_in, .pdata_drv, .slow, .send_n, .send_base,
		.got_data, .got_cnt, .sent_cnt);
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %0t ns: seen %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic test_done();
		$display("checks %0d, mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// A wait that ran out ends the run at once
	task automatic guard(input logic ok);
		if (ok !== 1'b1) begin
			fails++;
			$display("[ERR] %0t ns: wait ran out", $time);
			test_done();
		end
	endtask
	// Settled-level monitor: steady time before each answer, drive type
	always @(negedge clk_sys) begin
		hi_cnt <= busy_in ? hi_cnt + 1 : 0;
		lo_cnt <= nack_in ? 0 : lo_cnt + 1;
		prev_stb <= nstrobe_out;
		prev_afd <= nautofd_out;
		if (!reset && prev_stb === 1'b0 && nstrobe_out === 1'b1) begin
			check(32'(hi_cnt >= FILTER_CYC + EDGE_DLY_CYC), 32'h1);
		end
		if (!reset && port_direction_bit && prev_afd === 1'b0 && nautofd_out === 1'b1) begin
			check(32'(lo_cnt >= FILTER_CYC + EDGE_DLY_CYC), 32'h1);
		end
		if (!reset && prev_stb === 1'b1 && nstrobe_out === 1'b0) begin
			check(pdata_oe, mode == MODE_ECP ? 8'hFF : 8'(~pdata_out));
			check(nstrobe_oe, 1'b1);
		end
	end
	// Valid held until ready is seen high at a rising edge
	task automatic send_bytes(input logic [7:0] base, input int n);
		int i;
		for (int k = 0; k < n; k++) begin
			tx_data <= base + 8'(k);
			tx_valid <= 1'b1;
			for (i = 0; i < 200; i++) begin
				@(negedge clk_sys);
				if (tx_ready === 1'b1) break;
				@(posedge clk_sys);
			end
			guard(tx_ready === 1'b1);
			@(posedge clk_sys);
		end
		tx_valid <= 1'b0;
	endtask
	task automatic take_bytes(input logic [7:0] base, input int n);
		int i;
		rx_ready <= 1'b1;
		for (int k = 0; k < n; k++) begin
			for (i = 0; i < 600; i++) begin
				@(negedge clk_sys);
				if (rx_valid === 1'b1) break;
				@(posedge clk_sys);
			end
			guard(rx_valid === 1'b1);
			check(rx_data, base + 8'(k));
			@(posedge clk_sys);
		end
		rx_ready <= 1'b0;
	endtask
	task automatic wait_got(input logic [3:0] n);
		int i;
		for (i = 0; i < 400 && got_cnt !== n; i++) @(negedge clk_sys);
		guard(got_cnt === n);
		@(posedge clk_sys);
	endtask
	// Three bytes back to back, then the port must fall quiet
	task automatic t_forward(input mode_t m, input logic [7:0] base, input logic [3:0] lag);
		logic [3:0] k0;
		k0 = got_cnt;
		mode <= m;
		slow <= lag;
		send_bytes(base, 3);
		for (int k = 1; k <= 3; k++) begin
			wait_got(k0 + 4'(k));
			check(got_data, base + 8'(k - 1));
		end
		repeat (30) @(posedge clk_sys);
		check(nstrobe_w, 1'b1);
		check(nwrite_out, 1'b0);
	endtask
	// Peripheral asks for the reverse channel
	task automatic t_fault();
		int i;
		nfault_in <= 1'b0;
		@(posedge clk_sys);
		@(negedge clk_sys);
		check(reverse_request, 1'b0);
		for (i = 0; i < 20 && reverse_request !== 1'b1; i++) @(negedge clk_sys);
		check(reverse_request, 1'b1);
		@(posedge clk_sys);
		nfault_in <= 1'b1;
		repeat (20) @(posedge clk_sys);
		check(reverse_request, 1'b0);
	endtask
	// No reverse in FIFO mode; then a stalled receiver and a terminal count
	task automatic t_reverse();
		int i;
		port_direction_bit <= 1'b1;
		send_base <= 8'hA0;
		send_n <= 4'h4;
		repeat (60) @(posedge clk_sys);
		check(sent_cnt, 4'h0);
		check(nautofd_oe, 1'b0);
		mode <= MODE_ECP;
		for (i = 0; i < 600 && sent_cnt !== 4'h2; i++) @(posedge clk_sys);
		guard(sent_cnt === 4'h2);
		repeat (60) @(posedge clk_sys);
		check(sent_cnt, 4'h2);
		check(nautofd_w, 1'b0);
		check(nautofd_oe, 1'b1);
		take_bytes(8'hA0, 4);
		repeat (40) @(posedge clk_sys);
		check(nwrite_out, 1'b1);
		check(nautofd_w, 1'b0);
		terminal_count <= 1'b1;
		send_n <= 4'h5;
		repeat (60) @(posedge clk_sys);
		check(sent_cnt, 4'h4);
		terminal_count <= 1'b0;
		take_bytes(8'hA4, 1);
		port_direction_bit <= 1'b0;
	endtask
	// Reset, then each scenario in turn
	initial begin
		reset = 1'b1;
		mode = MODE_FIFO;
		port_direction_bit = 1'b0;
		terminal_count = 1'b0;
		nfault_in = 1'b1;
		tx_data = 8'h00;
		tx_valid = 1'b0;
		rx_ready = 1'b0;
		slow = 4'h0;
		send_n = 4'h0;
		send_base = 8'h00;
		repeat (6) @(posedge clk_sys);
		reset <= 1'b0;
		@(negedge clk_sys);
		check(nstrobe_w, 1'b1);
		check(tx_ready, 1'b1);
		check(rx_valid, 1'b0);
		@(posedge clk_sys);
		t_forward(MODE_ECP, 8'h51, 4'h0);
		t_fault();
		t_forward(MODE_FIFO, 8'h3C, 4'h3);
		t_reverse();
		t_forward(MODE_ECP, 8'hC0, 4'h2);
		test_done();
	end
endmodule
